// ### logic/plk_regs.vh
`ifndef PLK_REGS_VH
`define PLK_REGS_VH
// Register addresses on the command port (6-bit address).
`define PLK_ADDR_UNLOCK_KEY   6'h24
`define PLK_ADDR_SENS_FINE    6'h00
`define PLK_ADDR_ZERO_OFFSET  6'h01
`define PLK_ADDR_SENS_COARSE  6'h02
`define PLK_ADDR_CONFIG       6'h03
`define PLK_ADDR_STATUS       6'h04
// Config register field positions.
`define PLK_CFG_CLAMP_DIS_BIT 0
`define PLK_CFG_PERM_LOCK_BIT 1
// Command codes.
`define PLK_CMD_UNLOCK        2'h0
`define PLK_CMD_WR_VOL        2'h1
`define PLK_CMD_WR_NV         2'h2
`define PLK_CMD_READ          2'h3
// Timing at 200 MHz (5 ns period).
`define PLK_CLK_MHZ           200
`define PLK_RELEASE_US        100
`define PLK_RELEASE_CYC       (`PLK_RELEASE_US * `PLK_CLK_MHZ)
`define PLK_UNLOCK_WIN_MS     8
`define PLK_UNLOCK_WIN_CYC    (`PLK_UNLOCK_WIN_MS * 1000 * `PLK_CLK_MHZ)
// Default unlock key, value arbitrary.
`define PLK_KEY_DEFAULT       30'h2a5a5a5a
`endif

// ### logic/plk_por_timer.v
`timescale 1ns/1ps
`include "plk_regs.vh"
module plk_por_timer #(
    parameter RELEASE_CYC = `PLK_RELEASE_CYC
) (
    input  wire        core_clk,
    input  wire        arst_n,
    input  wire        supply_above_rise,
    input  wire        supply_below_fall,
    output reg         logic_reset
);
    reg  [31:0] count;

    ////////////////////////////////////////////////////////////////////////////
    // While held, the count restarts whenever the supply is not above the rise
    // threshold, so release only follows an unbroken stretch above it. Once
    // released, only the fall threshold brings reset back; the gap between the
    // two thresholds is hysteresis that keeps a noisy supply from chattering.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count       <= 32'h0;
            logic_reset <= 1'b1; // RULE1
        end else if (supply_below_fall) begin
            count       <= 32'h0;
            logic_reset <= 1'b1; // RULE4
        end else if (logic_reset && !supply_above_rise) begin
            count       <= 32'h0; // RULE3
        end else if (count < RELEASE_CYC - 1) begin
            count       <= count + 32'h1; // RULE2
        end else begin
            logic_reset <= 1'b0; // RULE3
        end
    end
endmodule

// ### logic/plk_lock_ctrl.v
`timescale 1ns/1ps
`include "plk_regs.vh"
// How it works
// RULE1 - Logic held in reset from power-up, output high impedance.
// RULE2 - Release counter starts when supply passes rise threshold.
// RULE3 - Release after terminal count with supply continuously above threshold.
// RULE4 - Supply at fall threshold reasserts reset and tristates output.
// RULE5 - Every power-up starts locked; all reads and writes refused.
// RULE6 - Writing the matching 30-bit key to 0x24 unlocks.
// RULE7 - Unlock only accepted within 8 ms of power-up.
// RULE8 - Once unlocked, access stays open for the power cycle.
// RULE9 - Power cycle restores the lock.
// RULE10 - Set permanent lock plus power cycle refuses all access forever.
// RULE11 - Permanent lock makes the unlock key ineffective.
// RULE12 - Permanent lock bit cannot be cleared once in effect.
// RULE13 - Gain from fine trim, zero-field level from offset trim.
// RULE14 - Controller should program gain before offset trim.
// RULE15 - Coarse gain factory-set but user writable.
// RULE16 - Clamp disable lets output swing to saturation limits.
// RULE17 - Access only via serial commands; device answers reads only.
// RULE18 - Four commands: unlock, write volatile, write nonvolatile, read.
// RULE19 - Unlock state volatile; permanent lock loaded from storage at release.
module plk_lock_ctrl #(
    parameter RELEASE_CYC = `PLK_RELEASE_CYC,
    parameter WINDOW_CYC  = `PLK_UNLOCK_WIN_CYC,
    parameter [29:0] KEY  = `PLK_KEY_DEFAULT
) (
    // Clock and power-up reset.
    input  wire        core_clk,
    input  wire        arst_n,
    // Supply comparator levels.
    input  wire        supply_above_rise,
    input  wire        supply_below_fall,
    // Storage image, sampled once when the reset releases.
    input  wire        nv_perm_lock,
    input  wire [8:0]  nv_sens_fine,
    input  wire [8:0]  nv_zero_offset,
    input  wire [2:0]  nv_sens_coarse,
    input  wire        nv_clamp_dis,
    // Command port from the serial front end.
    input  wire        cmd_valid,
    input  wire [1:0]  cmd_code,
    input  wire [5:0]  cmd_addr,
    input  wire [29:0] cmd_wdata,
    // Storage write request.
    output reg         nv_write,
    output reg  [5:0]  nv_addr,
    output reg  [29:0] nv_wdata,
    // Read answer.
    output reg         rd_ack,
    output reg  [29:0] rd_data,
    // Output driver enable.
    output wire        out_enable,
    // Trim and configuration levels.
    output reg  [8:0]  sens_fine,
    output reg  [8:0]  zero_field_offset_trim,
    output reg  [2:0]  sens_coarse,
    output reg         clamp_disable,
    // Lock state.
    output reg         unlocked,
    output reg         perm_locked
);
    wire        logic_reset;
    reg  [31:0] win_count;
    reg         win_open;
    reg         loaded;
    wire        access_ok;
    wire [4:0]  addr_sel;

    ////////////////////////////////////////////////////////////////////////////
    // Bit positions in the register select vector, one per addressable register.
    localparam SEL_FINE   = 0;
    localparam SEL_OFFSET = 1;
    localparam SEL_COARSE = 2;
    localparam SEL_CONFIG = 3;
    localparam SEL_STATUS = 4;

    // Address decode shared by the write and the read path, so that the two can
    // never disagree about which register an address names.
    function [4:0] plk_addr_sel;
        input [5:0] addr;
        begin
            plk_addr_sel = 5'h00;
            if (addr == `PLK_ADDR_SENS_FINE) begin
                plk_addr_sel[SEL_FINE] = 1'b1;
            end else if (addr == `PLK_ADDR_ZERO_OFFSET) begin
                plk_addr_sel[SEL_OFFSET] = 1'b1;
            end else if (addr == `PLK_ADDR_SENS_COARSE) begin
                plk_addr_sel[SEL_COARSE] = 1'b1;
            end else if (addr == `PLK_ADDR_CONFIG) begin
                plk_addr_sel[SEL_CONFIG] = 1'b1;
            end else if (addr == `PLK_ADDR_STATUS) begin
                plk_addr_sel[SEL_STATUS] = 1'b1;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Power-on release timing sits in its own module so it can be checked alone.
    plk_por_timer #(.RELEASE_CYC(RELEASE_CYC)) u_por (
        .core_clk          (core_clk),
        .arst_n            (arst_n),
        .supply_above_rise (supply_above_rise),
        .supply_below_fall (supply_below_fall),
        .logic_reset       (logic_reset)
    );

    // Output only drives while reset is released; until then the pin floats.
    assign out_enable = !logic_reset; // RULE1
    assign access_ok  = unlocked && !perm_locked; // RULE8
    // One decode serves both the write and the read path.
    assign addr_sel   = plk_addr_sel(cmd_addr);

    ////////////////////////////////////////////////////////////////////////////
    // The unlock window counts from power-up, independently of the release timer,
    // so a supply that takes long to settle eats into the window. After it closes
    // the counter stops, which keeps it from wrapping during long operation.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            win_count <= 32'h0;
            win_open  <= 1'b1;
        end else if (win_open) begin
            if (win_count >= WINDOW_CYC - 1) begin
                win_open <= 1'b0; // RULE7
            end else begin
                win_count <= win_count + 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lock state and trims. The internal reset holds the lock closed; the unlock
    // lives only in this volatile flop, so any power cycle brings the lock back
    // and the permanent lock bit is copied from storage once the reset releases.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            unlocked               <= 1'b0; // RULE5
            perm_locked            <= 1'b0;
            loaded                 <= 1'b0;
            sens_fine              <= 9'h000;
            zero_field_offset_trim <= 9'h000;
            sens_coarse            <= 3'h0;
            clamp_disable          <= 1'b0;
            nv_write               <= 1'b0;
            nv_addr                <= 6'h00;
            nv_wdata               <= 30'h0;
            rd_ack                 <= 1'b0;
            rd_data                <= 30'h0;
        end else if (logic_reset) begin
            // Trims keep their last values while held; they are reloaded from the
            // storage image at the next release, so nothing stale survives.
            unlocked <= 1'b0; // RULE9
            loaded   <= 1'b0;
            nv_write <= 1'b0;
            rd_ack   <= 1'b0;
        end else begin
            nv_write <= 1'b0;
            rd_ack   <= 1'b0;
            if (!loaded) begin
                // Image of storage copied once at release; the permanent lock
                // takes effect only here, which is why setting it needs a cycle.
                loaded                 <= 1'b1;
                perm_locked            <= nv_perm_lock; // RULE19
                sens_fine              <= nv_sens_fine;
                zero_field_offset_trim <= nv_zero_offset;
                sens_coarse            <= nv_sens_coarse; // RULE15
                clamp_disable          <= nv_clamp_dis;
            end else if (cmd_valid) begin
                // Commands arrive already framed by the serial front end; an unknown
                // address writes no register but still reaches storage on a nonvolatile write, and reads back as zero.
                case (cmd_code) // RULE18
                `PLK_CMD_UNLOCK: begin
                    // The key counts only inside the window and never under the
                    // permanent lock, so a late glitch cannot open the registers.
                    if (cmd_addr == `PLK_ADDR_UNLOCK_KEY && cmd_wdata == KEY &&
                        win_open && !perm_locked) begin
                        unlocked <= 1'b1; // RULE6 RULE11
                    end
                end
                `PLK_CMD_WR_VOL, `PLK_CMD_WR_NV: begin
                    if (access_ok) begin // RULE10
                        if (addr_sel[SEL_FINE]) begin
                            sens_fine <= cmd_wdata[8:0]; // RULE13
                        end else if (addr_sel[SEL_OFFSET]) begin
                            zero_field_offset_trim <= cmd_wdata[8:0]; // RULE13
                        end else if (addr_sel[SEL_COARSE]) begin
                            sens_coarse <= cmd_wdata[2:0]; // RULE15
                        end else if (addr_sel[SEL_CONFIG]) begin
                            clamp_disable <= cmd_wdata[`PLK_CFG_CLAMP_DIS_BIT]; // RULE16
                        end
                        if (cmd_code == `PLK_CMD_WR_NV) begin
                            // Permanent lock only written to storage, so it only
                            // takes effect after a power cycle and never clears.
                            nv_write <= 1'b1; // RULE12
                            nv_addr  <= cmd_addr;
                            nv_wdata <= cmd_wdata;
                        end
                    end
                end
                default: begin
                    // Only reads are answered, and only when open; a refused read
                    // stays silent so a locked part reveals nothing of its trims.
                    if (access_ok) begin // RULE17
                        rd_ack <= 1'b1;
                        if (addr_sel[SEL_FINE]) begin
                            rd_data <= {21'h0, sens_fine};
                        end else if (addr_sel[SEL_OFFSET]) begin
                            rd_data <= {21'h0, zero_field_offset_trim};
                        end else if (addr_sel[SEL_COARSE]) begin
                            rd_data <= {27'h0, sens_coarse};
                        end else if (addr_sel[SEL_CONFIG]) begin
                            rd_data <= {28'h0, perm_locked, clamp_disable};
                        end else if (addr_sel[SEL_STATUS]) begin
                            rd_data <= {27'h0, win_open, unlocked, perm_locked};
                        end else begin
                            rd_data <= 30'h0;
                        end
                    end
                end
                endcase
            end
        end
    end
endmodule

// ### bench/plk_chk_properties.sv
`timescale 1ns/1ps
// Watches the release and lock behaviour at the controller's ports.
module plk_chk (
    input wire       core_clk,
    input wire       arst_n,
    input wire       supply_above_rise,
    input wire       supply_below_fall,
    input wire       cmd_valid,
    input wire [1:0] cmd_code,
    input wire [5:0] cmd_addr,
    input wire       rd_ack,
    input wire       nv_write,
    input wire       out_enable,
    input wire       unlocked,
    input wire       perm_locked
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Access relations; a supply drop is excluded since it resets the logic.
    a_read_answered: assert property (
        cmd_valid && cmd_code == 2'h3 && unlocked && !supply_below_fall |=> rd_ack)
        else $error("read not answered");
    a_ack_needs_open: assert property (rd_ack |-> $past(cmd_valid) && $past(unlocked))
        else $error("answer while locked");
    a_write_needs_open: assert property (nv_write |-> $past(unlocked))
        else $error("storage write while locked");
    a_perm_no_unlock: assert property (perm_locked |-> !unlocked)
        else $error("unlocked under permanent lock");
    a_unlock_kept: assert property (
        unlocked && !supply_below_fall && !$past(supply_below_fall) |=> unlocked)
        else $error("unlock lost");
    a_unlock_cause: assert property ($rose(unlocked) |-> $past(cmd_valid) &&
        $past(cmd_code) == 2'h0 && $past(cmd_addr) == 6'h24)
        else $error("unlock without key command");
    // Output enable follows the supply thresholds.
    a_oe_drops: assert property (supply_below_fall |-> ##[0:2] !out_enable)
        else $error("output driven at low supply");
    a_oe_needs_supply: assert property ($rose(out_enable) |->
        $past(supply_above_rise, 8) && !$past(supply_below_fall))
        else $error("release without steady supply");
endmodule
bind plk_lock_ctrl plk_chk plk_chk_inst (.core_clk, .arst_n, .supply_above_rise,
    .supply_below_fall, .cmd_valid, .cmd_code, .cmd_addr, .rd_ack, .nv_write,
    .out_enable, .unlocked, .perm_locked);

// ### bench/plk_ctl_model.sv
`timescale 1ns/1ps
// Programming controller; it alone starts traffic, one command a call.
module plk_ctl_model (
    input  wire        core_clk,
    output reg         cmd_valid,
    output reg  [1:0]  cmd_code,
    output reg  [5:0]  cmd_addr,
    output reg  [29:0] cmd_wdata
);
    // The port starts idle, so nothing unknown is offered before the first call.
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 2'h0;
        cmd_addr = 6'h00;
        cmd_wdata = 30'h0;
    end
    // Idle fields are inverted so a stale value is never trusted.
    task send(input [1:0] c, input [5:0] a, input [29:0] d);
        begin
            @(negedge core_clk);
            cmd_valid = 1'b1;
            cmd_code = c;
            cmd_addr = a;
            cmd_wdata = d;
            @(negedge core_clk);
            cmd_valid = 1'b0;
            cmd_code = ~c;
            cmd_addr = ~a;
            cmd_wdata = ~d;
        end
    endtask
endmodule

// ### bench/tb_plk_lock_ctrl.sv
`timescale 1ns/1ps
`include "plk_regs.vh"
module tb_plk_lock_ctrl;
    reg        core_clk, arst_n, supply_above_rise, supply_below_fall, nv_perm_lock, nv_clamp_dis;
    reg  [8:0] nv_sens_fine, nv_zero_offset;
    reg  [2:0] nv_sens_coarse;
    wire       cmd_valid, nv_write, rd_ack, out_enable, clamp_disable, unlocked, perm_locked;
    wire [1:0] cmd_code;
    wire [5:0] cmd_addr, nv_addr;
    wire [29:0] cmd_wdata, nv_wdata, rd_data;
    wire [8:0] sens_fine, zero_field_offset_trim;
    wire [2:0] sens_coarse;
    integer    num_errors = 0, checks = 0;
    plk_lock_ctrl #(.RELEASE_CYC(16), .WINDOW_CYC(200)) plk_lock_ctrl_inst (.core_clk, .arst_n,
        .supply_above_rise, .supply_below_fall, .nv_perm_lock, .nv_sens_fine, .nv_zero_offset,
        .nv_sens_coarse, .nv_clamp_dis, .cmd_valid, .cmd_code, .cmd_addr, .cmd_wdata, .nv_write,
        .nv_addr, .nv_wdata, .rd_ack, .rd_data, .out_enable, .sens_fine,
        .zero_field_offset_trim, .sens_coarse, .clamp_disable, .unlocked, .perm_locked);
    plk_ctl_model plk_ctl_model_inst (.core_clk, .cmd_valid, .cmd_code, .cmd_addr, .cmd_wdata);
    ////////////////////////////////////////////////////////////////
    // Clock at 200 MHz.
    always #2.5 core_clk = ~core_clk;
    task chk(input [29:0] s, input [29:0] e);
        begin
            checks = checks + 1;
            if (s !== e) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, s, e);
            end
        end
    endtask
    task conclude;
        begin
            if (num_errors == 0 && checks > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    task cmd(input [1:0] c, input [5:0] a, input [29:0] d);
        plk_ctl_model_inst.send(c, a, d);
    endtask
    // Power cycle; the supply rises late so the count must start from it.
    task power(input p);
        integer n;
        begin
            arst_n = 1'b0;
            supply_above_rise = 1'b0;
            nv_perm_lock = p;
            repeat (12) @(negedge core_clk);
            arst_n = 1'b1;
            repeat (30) @(negedge core_clk);
            chk(out_enable, 1'b0);
            // A dip during the count must restart it from zero.
            supply_above_rise = 1'b1;
            repeat (8) @(negedge core_clk);
            supply_above_rise = 1'b0;
            @(negedge core_clk);
            chk(out_enable, 1'b0);
            supply_above_rise = 1'b1;
            n = 0;
            while (out_enable !== 1'b1 && n < 60) begin
                @(negedge core_clk);
                n = n + 1;
            end
            chk({out_enable, n == 16}, 2'h3);
            repeat (2) @(negedge core_clk);
            chk({perm_locked, sens_fine}, {p, nv_sens_fine});
        end
    endtask
    task t_open;
        begin
            power(1'b0);
            cmd(`PLK_CMD_READ, `PLK_ADDR_SENS_FINE, 30'h0);
            chk(rd_ack, 1'b0);
            cmd(`PLK_CMD_UNLOCK, `PLK_ADDR_UNLOCK_KEY, ~`PLK_KEY_DEFAULT);
            chk(unlocked, 1'b0);
            cmd(`PLK_CMD_UNLOCK, `PLK_ADDR_UNLOCK_KEY, `PLK_KEY_DEFAULT);
            chk(unlocked, 1'b1);
            cmd(`PLK_CMD_READ, `PLK_ADDR_STATUS, 30'h0);
            chk(rd_data, 30'h6);
            cmd(`PLK_CMD_WR_VOL, `PLK_ADDR_SENS_FINE, 30'h1a5);
            cmd(`PLK_CMD_WR_VOL, `PLK_ADDR_ZERO_OFFSET, 30'h0c3);
            cmd(`PLK_CMD_WR_VOL, `PLK_ADDR_SENS_COARSE, 30'h5);
            cmd(`PLK_CMD_WR_VOL, `PLK_ADDR_CONFIG, 30'h1);
            chk(rd_ack, 1'b0);
            cmd(`PLK_CMD_READ, `PLK_ADDR_SENS_FINE, 30'h0);
            chk(rd_ack, 1'b1);
            chk(rd_data, 30'h1a5);
            chk({sens_fine, zero_field_offset_trim}, {9'h1a5, 9'h0c3});
            chk({sens_coarse, clamp_disable}, 4'hb);
            cmd(`PLK_CMD_WR_NV, `PLK_ADDR_CONFIG, 30'h2);
            chk(nv_wdata, 30'h2);
            chk({nv_write, nv_addr}, {1'b1, `PLK_ADDR_CONFIG});
            power(1'b0);
            chk(unlocked, 1'b0);
        end
    endtask
    task t_late;
        begin
            power(1'b0);
            repeat (200) @(negedge core_clk);
            cmd(`PLK_CMD_UNLOCK, `PLK_ADDR_UNLOCK_KEY, `PLK_KEY_DEFAULT);
            chk(unlocked, 1'b0);
        end
    endtask
    task t_perm;
        begin
            power(1'b1);
            cmd(`PLK_CMD_UNLOCK, `PLK_ADDR_UNLOCK_KEY, `PLK_KEY_DEFAULT);
            chk(unlocked, 1'b0);
            cmd(`PLK_CMD_READ, `PLK_ADDR_CONFIG, 30'h0);
            chk(rd_ack, 1'b0);
            cmd(`PLK_CMD_WR_NV, `PLK_ADDR_CONFIG, 30'h3ffffffd);
            chk(nv_wdata, 30'h0);
            chk(nv_write, 1'b0);
            supply_below_fall = 1'b1;
            repeat (3) @(negedge core_clk);
            chk(out_enable, 1'b0);
        end
    endtask
    // Main sequence; the storage image is fixed for the whole run except nv_perm_lock, which each power call sets.
    initial begin
        core_clk = 1'b0;
        supply_below_fall = 1'b0;
        nv_clamp_dis = 1'b0;
        nv_sens_fine = 9'h0f0;
        nv_zero_offset = 9'h100;
        nv_sens_coarse = 3'h2;
        t_open;
        t_late;
        t_perm;
        conclude;
    end
    // Watchdog well beyond the expected run of about five hundred cycles.
    initial begin
        #20000;
        num_errors = num_errors + 1;
        conclude;
    end
endmodule
